// ===== hw/sensor_consts.vh
// Constants for the speed sensor supervision block.
`ifndef SENSOR_CONSTS_VH
`define SENSOR_CONSTS_VH
`define CLK_FREQ_HZ        25000000
`define FAULT_HOLD_US      1000
`define FAULT_HOLD_CYCLES  ((`CLK_FREQ_HZ / 1000000) * `FAULT_HOLD_US + 1)
`define SAMPLE_W           12
`define HYST_BAND          12'h040
`define MIN_SPAN           12'h080
`define STEP_LIMIT         12'h010
`define STOP_TIMEOUT       24'h0F4240
`define GAIN_W             8
`define GAIN_UNITY         8'h80
`define LVL_POS            3'h0
`define LVL_LOW            3'h1
`define LVL_HIGH           3'h2
`define LVL_RAIL_LOW       3'h3
`define LVL_FAULT_HIGH     3'h4
`define INT_HOLD_DONE      0
`define INT_DIAG           1
`define INT_LOCK_A         2
`define INT_LOCK_B         3
`define INT_W              4
`endif

// ===== hw/channel_tracker.v
// Peak tracker and switch comparator for one differential channel.
`timescale 1ns/1ps
`include "sensor_consts.vh"
module channel_tracker #(
  parameter W          = `SAMPLE_W,
  parameter STOP_LIMIT = `STOP_TIMEOUT
) (
  // Clock and reset
  input  wire                   clk,
  input  wire                   reset,
  // Sample stream
  input  wire                   sample_valid,
  input  wire signed [W-1:0]    sample,
  input  wire [`GAIN_W-1:0]     temp_gain,
  // Threshold mode
  input  wire                   fixed_mode,
  input  wire signed [W-1:0]    fixed_init,
  // Status
  output reg                    started_q,
  output reg                    span_ok_q,
  output reg                    switch_q,
  output reg                    dir_change_q,
  output reg signed [W-1:0]     fixed_thr_q
);
  reg signed [W-1:0] max_q;
  reg signed [W-1:0] min_q;
  reg signed [W-1:0] first_q;
  reg                first_seen_q;
  reg                rising_q;
  reg signed [W-1:0] last_q;
  reg [23:0]         idle_q;
  reg signed [W+`GAIN_W:0] prod;
  reg signed [W-1:0] norm;
  reg signed [W:0]   span;
  reg signed [W-1:0] mid;
  reg signed [W-1:0] move;
  reg                now_rising;
  always @* begin
    prod       = sample * $signed({1'b0, temp_gain});
    norm       = prod[W+`GAIN_W-2:`GAIN_W-1];
    span       = {max_q[W-1], max_q} - {min_q[W-1], min_q};
    mid        = max_q - span[W:1];
    move       = norm - first_q;
    now_rising = norm > last_q;
  end
  always @(posedge clk) begin
    if (reset) begin
      max_q        <= {W{1'b0}};
      min_q        <= {W{1'b0}};
      first_q      <= {W{1'b0}};
      first_seen_q <= 1'b0;
      started_q    <= 1'b0;
      span_ok_q    <= 1'b0;
      switch_q     <= 1'b0;
      dir_change_q <= 1'b0;
      rising_q     <= 1'b0;
      last_q       <= {W{1'b0}};
      idle_q       <= 24'h000000;
      fixed_thr_q  <= {W{1'b0}};
    end else begin
      dir_change_q <= 1'b0;
      if (!first_seen_q) begin
        fixed_thr_q <= fixed_init;
      end
      if (sample_valid) begin
        last_q   <= norm;
        rising_q <= now_rising;
        if (!first_seen_q) begin
          first_q      <= norm;
          first_seen_q <= 1'b1;
          max_q        <= norm;
          min_q        <= norm;
        end else if (!started_q) begin
          // No tracking until the signal leaves the band around its first value.
          if (move > $signed(`HYST_BAND) || move < -$signed(`HYST_BAND)) begin
            started_q <= 1'b1;
          end
        end else begin
          idle_q <= 24'h000000;
          if (now_rising != rising_q) begin
            dir_change_q <= 1'b1;
          end
          // Outward moves limited in step; inward moves only outside a reversal.
          if (norm > max_q) begin
            max_q <= (norm - max_q > $signed(`STEP_LIMIT)) ? max_q + $signed(`STEP_LIMIT) : norm;
          end else if (now_rising == rising_q && !now_rising) begin
            max_q <= max_q - 1'b1;
          end
          if (norm < min_q) begin
            min_q <= (min_q - norm > $signed(`STEP_LIMIT)) ? min_q - $signed(`STEP_LIMIT) : norm;
          end else if (now_rising == rising_q && now_rising) begin
            min_q <= min_q + 1'b1;
          end
          span_ok_q <= span > $signed({1'b0, `MIN_SPAN});
          if (fixed_mode) begin
            switch_q <= norm > fixed_thr_q;
            if (fixed_thr_q > max_q || fixed_thr_q < min_q) begin
              fixed_thr_q <= mid;
            end
          end else begin
            switch_q <= norm > mid;
          end
        end
      end else if (started_q) begin
        if (idle_q == STOP_LIMIT) begin
          // Stopped target: shift both peaks together so the span is kept.
          idle_q <= 24'h000000;
          if (last_q > mid) begin
            max_q <= max_q + 1'b1;
            min_q <= min_q + 1'b1;
          end else if (last_q < mid) begin
            max_q <= max_q - 1'b1;
            min_q <= min_q - 1'b1;
          end
        end else begin
          idle_q <= idle_q + 24'h000001;
        end
      end
    end
  end
endmodule

// ===== hw/irq_status.v
// Sticky interrupt status with write-one-to-clear and a mask.
`timescale 1ns/1ps
`include "sensor_consts.vh"
module irq_status #(
  parameter N = `INT_W
) (
  // Clock and reset
  input  wire         clk,
  input  wire         reset,
  // Events and software access
  input  wire [N-1:0] events,
  input  wire         clr_we,
  input  wire [N-1:0] clr_bits,
  input  wire         mask_we,
  input  wire [N-1:0] mask_bits,
  // State
  output reg  [N-1:0] status_q,
  output reg  [N-1:0] mask_q,
  output reg          irq_q
);
  wire [N-1:0] status_d;
  // A new event wins over a clear in the same cycle.
  assign status_d = (status_q & ~(clr_we ? clr_bits : {N{1'b0}})) | events;
  always @(posedge clk) begin
    if (reset) begin
      status_q <= {N{1'b0}};
      mask_q   <= {N{1'b0}};
      irq_q    <= 1'b0;
    end else begin
      status_q <= status_d;
      if (mask_we) begin
        mask_q <= mask_bits;
      end
      irq_q <= |(status_d & (mask_we ? mask_bits : mask_q));
    end
  end
endmodule

// ===== hw/sensor_supervisor.v
// Output fault, undervoltage and lockout supervision for a two channel speed sensor.
//
// Overview of operation
// - Fault level held longer than one millisecond.
// - Internal diagnostic forces both outputs high fault.
// - Undervoltage holds reset with power-on output state.
// - Startup hysteresis blocks tracking until signal moves.
// - Small span holds output at last valid level.
// - Non-direction protocols lock each channel separately.
// - Direction protocols lock when either channel small.
// - Direction change stops inward peak movement.
// - Tracking update steps are limited.
// - Peak tracking follows offset drift during rotation.
// - Stopped target watchdog moves peaks together.
// - Temperature gain normalises amplitude before tracking.
// - Fixed threshold updated per channel for drift.
// - Reduced swing levels only with fault detection.
// - Clearable fault resets controller after hold.
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`include "sensor_consts.vh"
module sensor_supervisor #(
  parameter W           = `SAMPLE_W,
  parameter HOLD_CYCLES = `FAULT_HOLD_CYCLES,
  parameter STOP_LIMIT  = `STOP_TIMEOUT
) (
  // Clock and reset
  input  wire                clk,
  input  wire                reset,
  // Supply monitor
  input  wire                supply_undervoltage_threshold,
  // Channel samples
  input  wire                sample_valid,
  input  wire signed [W-1:0] sample_a,
  input  wire signed [W-1:0] sample_b,
  input  wire [`GAIN_W-1:0]  temp_gain,
  // Configuration straps
  input  wire                fault_detect_en,
  input  wire                direction_protocol,
  input  wire                fixed_mode,
  input  wire signed [W-1:0] fixed_init_a,
  input  wire signed [W-1:0] fixed_init_b,
  // Diagnostics
  input  wire                diag_fault,
  input  wire                diag_clearable,
  // Software register port
  input  wire [1:0]          reg_addr,
  input  wire [7:0]          reg_wdata,
  input  wire                reg_wr,
  input  wire                reg_rd,
  output reg  [7:0]          reg_rdata_q,
  // Output pin drivers
  output reg  [2:0]          first_output_pin_q,
  output reg  [2:0]          second_output_pin_q,
  output reg                 first_output_pin_oe_q,
  output reg                 second_output_pin_oe_q,
  // Controller reset and interrupt
  output reg                 ctrl_reset_q,
  output reg                 irq_q
);
  localparam [1:0] ADDR_STATUS = 2'h0;
  localparam [1:0] ADDR_MASK   = 2'h1;
  localparam [1:0] ADDR_STATE  = 2'h2;
  localparam [3:0] ST_RESET = 4'h1;
  localparam [3:0] ST_RUN   = 4'h2;
  localparam [3:0] ST_FAULT = 4'h4;
  localparam [3:0] ST_DEAD  = 4'h8;
  localparam [23:0] HOLD_LAST = HOLD_CYCLES[23:0] - 24'h000001;

  reg  [3:0]  state_q;
  reg  [23:0] hold_q;
  reg         clearable_q;
  reg         out_a_q;
  reg         out_b_q;
  reg         lock_a_q;
  reg         lock_b_q;
  reg         hold_done_q;
  wire        core_reset;
  wire        started_a;
  wire        started_b;
  wire        span_ok_a;
  wire        span_ok_b;
  wire        switch_a;
  wire        switch_b;
  wire        dir_a;
  wire        dir_b;
  wire [`INT_W-1:0] status;
  wire [`INT_W-1:0] mask;
  wire              irq;
  wire [`INT_W-1:0] events;
  reg               lock_a_d;
  reg               lock_b_d;

  ////////////////////////////////////////////////////////////////////////
  // Tracking channels, restarted with the controller.
  assign core_reset = reset | supply_undervoltage_threshold | ctrl_reset_q;

  channel_tracker #(
    .W          (W),
    .STOP_LIMIT (STOP_LIMIT)
  ) u_track_a (
    .clk          (clk),
    .reset        (core_reset),
    .sample_valid (sample_valid),
    .sample       (sample_a),
    .temp_gain    (temp_gain),
    .fixed_mode   (fixed_mode),
    .fixed_init   (fixed_init_a),
    .started_q    (started_a),
    .span_ok_q    (span_ok_a),
    .switch_q     (switch_a),
    .dir_change_q (dir_a),
    .fixed_thr_q  ()
  );

  channel_tracker #(
    .W          (W),
    .STOP_LIMIT (STOP_LIMIT)
  ) u_track_b (
    .clk          (clk),
    .reset        (core_reset),
    .sample_valid (sample_valid),
    .sample       (sample_b),
    .temp_gain    (temp_gain),
    .fixed_mode   (fixed_mode),
    .fixed_init   (fixed_init_b),
    .started_q    (started_b),
    .span_ok_q    (span_ok_b),
    .switch_q     (switch_b),
    .dir_change_q (dir_b),
    .fixed_thr_q  ()
  );

  ////////////////////////////////////////////////////////////////////////
  // Small signal lockout.
  always @* begin
    if (direction_protocol) begin
      lock_a_d = !(span_ok_a && span_ok_b);
      lock_b_d = lock_a_d;
    end else begin
      lock_a_d = !span_ok_a;
      lock_b_d = !span_ok_b;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output state machine.
  always @(posedge clk) begin
    if (reset || supply_undervoltage_threshold) begin
      state_q      <= ST_RESET;
      hold_q       <= 24'h000000;
      clearable_q  <= 1'b0;
      out_a_q      <= 1'b0;
      out_b_q      <= 1'b0;
      // Trackers leave reset without a valid span, so the lock flags start set and no lockout event follows reset.
      lock_a_q     <= 1'b1;
      lock_b_q     <= 1'b1;
      hold_done_q  <= 1'b0;
      ctrl_reset_q <= 1'b0;
    end else begin
      hold_done_q  <= 1'b0;
      ctrl_reset_q <= 1'b0;
      lock_a_q     <= lock_a_d;
      lock_b_q     <= lock_b_d;
      case (state_q)
        ST_RESET: begin
          state_q <= ST_RUN;
        end
        ST_RUN: begin
          if (diag_fault && fault_detect_en) begin
            state_q     <= ST_FAULT;
            hold_q      <= 24'h000000;
            clearable_q <= diag_clearable;
          end else begin
            // Locked channels keep their last in-spec level.
            if (!lock_a_d && started_a) begin
              out_a_q <= switch_a;
            end
            if (!lock_b_d && started_b) begin
              out_b_q <= switch_b;
            end
          end
        end
        ST_FAULT: begin
          // Only reset or undervoltage may move the pins before the hold has run out.
          if (hold_q == HOLD_LAST) begin
            hold_done_q <= 1'b1;
            if (clearable_q) begin
              state_q      <= ST_RESET;
              ctrl_reset_q <= 1'b1;
            end else begin
              state_q <= ST_DEAD;
            end
          end else begin
            hold_q <= hold_q + 24'h000001;
          end
        end
        ST_DEAD: begin
          state_q <= ST_DEAD;
        end
        default: begin
          state_q <= ST_RESET;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin level encoding; the fault range needs the reduced swing.
  always @(posedge clk) begin
    if (reset || supply_undervoltage_threshold) begin
      first_output_pin_q     <= `LVL_POS;
      second_output_pin_q    <= `LVL_POS;
      first_output_pin_oe_q  <= 1'b0;
      second_output_pin_oe_q <= 1'b0;
    end else begin
      first_output_pin_oe_q  <= 1'b1;
      second_output_pin_oe_q <= 1'b1;
      if (state_q == ST_FAULT || state_q == ST_DEAD) begin
        first_output_pin_q  <= `LVL_FAULT_HIGH;
        second_output_pin_q <= `LVL_FAULT_HIGH;
      end else if (state_q == ST_RESET) begin
        first_output_pin_q  <= `LVL_POS;
        second_output_pin_q <= `LVL_POS;
      end else if (fault_detect_en) begin
        first_output_pin_q  <= out_a_q ? `LVL_HIGH : `LVL_LOW;
        second_output_pin_q <= out_b_q ? `LVL_HIGH : `LVL_LOW;
      end else begin
        first_output_pin_q  <= out_a_q ? `LVL_POS : `LVL_RAIL_LOW;
        second_output_pin_q <= out_b_q ? `LVL_POS : `LVL_RAIL_LOW;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupts and register port.
  assign events[`INT_HOLD_DONE] = hold_done_q;
  assign events[`INT_DIAG]      = (state_q == ST_RUN) && diag_fault && fault_detect_en;
  assign events[`INT_LOCK_A]    = lock_a_d && !lock_a_q;
  assign events[`INT_LOCK_B]    = lock_b_d && !lock_b_q;

  irq_status #(
    .N (`INT_W)
  ) u_irq (
    .clk       (clk),
    .reset     (reset),
    .events    (events),
    .clr_we    (reg_wr && reg_addr == ADDR_STATUS),
    .clr_bits  (reg_wdata[`INT_W-1:0]),
    .mask_we   (reg_wr && reg_addr == ADDR_MASK),
    .mask_bits (reg_wdata[`INT_W-1:0]),
    .status_q  (status),
    .mask_q    (mask),
    .irq_q     (irq)
  );

  always @(posedge clk) begin
    if (reset) begin
      reg_rdata_q <= 8'h00;
      irq_q       <= 1'b0;
    end else begin
      irq_q <= irq;
      if (reg_rd) begin
        case (reg_addr)
          ADDR_STATUS: reg_rdata_q <= {4'h0, status};
          ADDR_MASK:   reg_rdata_q <= {4'h0, mask};
          ADDR_STATE:  reg_rdata_q <= {state_q, lock_b_q, lock_a_q, started_b, started_a};
          default:     reg_rdata_q <= 8'h00;
        endcase
      end else begin
        reg_rdata_q <= 8'h00;
      end
    end
  end
endmodule

// ===== tb/sensor_supervisor_monitor.sv
// Concurrent checks on the supervisor's output pins and controller reset.
`timescale 1ns/1ps
`include "sensor_consts.vh"
module sensor_supervisor_monitor #(
  parameter HOLD_CYCLES = 20
) (
  // Clock, reset and inputs
  input wire       clk,
  input wire       reset,
  input wire       supply_undervoltage_threshold,
  input wire       fault_detect_en,
  input wire       diag_fault,
  // Pins and controller reset
  input wire [2:0] first_output_pin_q,
  input wire [2:0] second_output_pin_q,
  input wire       first_output_pin_oe_q,
  input wire       second_output_pin_oe_q,
  input wire       ctrl_reset_q
);
  logic [31:0] hold_cnt_q;
  logic [31:0] last_hold_q;
  wire         at_fault = first_output_pin_q == `LVL_FAULT_HIGH;
  // Length of the current fault run including this cycle, or of the last one once the pin has left.
  wire  [31:0] run_len  = at_fault ? hold_cnt_q + 32'h1 : last_hold_q;
  // The last run length is kept after the pin leaves so a late controller reset is still judged.
  always @(posedge clk) begin
    if (reset) begin
      hold_cnt_q  <= 32'h0;
      last_hold_q <= 32'h0;
    end else begin
      hold_cnt_q  <= at_fault ? hold_cnt_q + 32'h1 : 32'h0;
      last_hold_q <= at_fault ? hold_cnt_q + 32'h1 : last_hold_q;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence fault_taken;
    diag_fault && fault_detect_en && first_output_pin_oe_q && !at_fault && !supply_undervoltage_threshold;
  endsequence
  sequence left_fault;
    $past(first_output_pin_q) == `LVL_FAULT_HIGH && !at_fault && !supply_undervoltage_threshold;
  endsequence
  fault_both_a: assert property (at_fault == (second_output_pin_q == `LVL_FAULT_HIGH))
    else $error("Only one pin at fault level");
  fault_entry_a: assert property (fault_taken |-> ##2 at_fault)
    else $error("Fault level not reached two cycles after diagnostic");
  fault_hold_a: assert property (left_fault |-> last_hold_q >= HOLD_CYCLES)
    else $error("Fault level left too early");
  ctrl_after_a: assert property ($rose(ctrl_reset_q) |-> run_len >= HOLD_CYCLES)
    else $error("Controller reset before fault hold elapsed");
  ctrl_pulse_a: assert property (ctrl_reset_q |=> !ctrl_reset_q)
    else $error("Controller reset longer than one cycle");
  uv_pos_a: assert property (supply_undervoltage_threshold [*2] |->
    first_output_pin_q == `LVL_POS && !first_output_pin_oe_q && !second_output_pin_oe_q)
    else $error("Pins not at power-on state in undervoltage");
  swing_reduced_a: assert property (fault_detect_en && $stable(fault_detect_en) |->
    first_output_pin_q != `LVL_RAIL_LOW && second_output_pin_q != `LVL_RAIL_LOW)
    else $error("Rail level used with fault detection on");
  swing_full_a: assert property (!fault_detect_en && $stable(fault_detect_en) |->
    !at_fault && first_output_pin_q != `LVL_LOW && first_output_pin_q != `LVL_HIGH)
    else $error("Reduced swing or fault level used with fault detection off");
endmodule

bind sensor_supervisor sensor_supervisor_monitor #(.HOLD_CYCLES(HOLD_CYCLES)) i_sensor_supervisor_monitor (
  .clk(clk), .reset(reset), .supply_undervoltage_threshold(supply_undervoltage_threshold),
  .fault_detect_en(fault_detect_en), .diag_fault(diag_fault), .first_output_pin_q(first_output_pin_q),
  .second_output_pin_q(second_output_pin_q), .first_output_pin_oe_q(first_output_pin_oe_q),
  .second_output_pin_oe_q(second_output_pin_oe_q), .ctrl_reset_q(ctrl_reset_q));

// ===== tb/fault_watcher.sv
// System controller model that watches one output pin for held fault ranges.
`timescale 1ns/1ps
`include "sensor_consts.vh"
module fault_watcher #(
  parameter HOLD_CYCLES = 20
) (
  input  wire       clk,
  input  wire       reset,
  input  wire       monitor_en,
  input  wire [2:0] pin_level,
  input  wire       pin_oe,
  output logic      fault_seen
);
  logic [1:0]  range_q;
  logic [31:0] cnt_q;
  // A released open-drain pin floats up to the pull-up, which is the high fault range.
  wire  [1:0]  range_now = !monitor_en ? 2'h0 :
                           (!pin_oe || pin_level == `LVL_POS || pin_level == `LVL_FAULT_HIGH) ? 2'h1 :
                           (pin_level == `LVL_RAIL_LOW) ? 2'h2 : 2'h0;
  always @(posedge clk) begin
    range_q <= range_now;
    if (reset || range_now == 2'h0 || range_now != range_q) begin
      cnt_q <= 32'h0;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
    // The count lags the range by two samples, so this fires once the range has stood HOLD_CYCLES samples.
    fault_seen <= reset ? 1'b0 : (fault_seen || cnt_q >= HOLD_CYCLES - 2);
  end
endmodule

// ===== tb/speed_sensor_fault_and_lockout_control_tb_top.sv
// Self-checking bench for the speed sensor supervision block.
`timescale 1ns/1ps
`include "sensor_consts.vh"
module speed_sensor_fault_and_lockout_control_tb_top;
  localparam int HOLD = 20;
  logic              clk, reset, uv, sample_valid, fault_detect_en, direction_protocol, fixed_mode;
  logic              diag_fault, diag_clearable, reg_wr, reg_rd;
  logic signed [11:0] sample_a, sample_b, fixed_init_a, fixed_init_b;
  logic [7:0]        temp_gain, reg_wdata;
  logic [1:0]        reg_addr;
  wire  [7:0]        rdata;
  wire  [2:0]        pin_a, pin_b;
  wire               oe_a, oe_b, ctrl_rst, irq, seen_a, seen_b;
  int                fails, comparisons;

  sensor_supervisor #(.HOLD_CYCLES(HOLD), .STOP_LIMIT(50)) i_sensor_supervisor (
    .clk(clk), .reset(reset), .supply_undervoltage_threshold(uv), .sample_valid(sample_valid),
    .sample_a(sample_a), .sample_b(sample_b), .temp_gain(temp_gain), .fault_detect_en(fault_detect_en),
    .direction_protocol(direction_protocol), .fixed_mode(fixed_mode), .fixed_init_a(fixed_init_a),
    .fixed_init_b(fixed_init_b), .diag_fault(diag_fault), .diag_clearable(diag_clearable),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(rdata),
    .first_output_pin_q(pin_a), .second_output_pin_q(pin_b), .first_output_pin_oe_q(oe_a),
    .second_output_pin_oe_q(oe_b), .ctrl_reset_q(ctrl_rst), .irq_q(irq));
  fault_watcher #(.HOLD_CYCLES(HOLD)) i_fault_watcher (.clk(clk), .reset(reset), .monitor_en(fault_detect_en),
    .pin_level(pin_a), .pin_oe(oe_a), .fault_seen(seen_a));
  fault_watcher #(.HOLD_CYCLES(HOLD)) i_fault_watcher_b (.clk(clk), .reset(reset), .monitor_en(fault_detect_en),
    .pin_level(pin_b), .pin_oe(oe_b), .fault_seen(seen_b));

  ////////////////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic do_reset(input logic fde, input logic dirp);
    @(posedge clk);
    reset <= 1'b1;
    fault_detect_en <= fde;
    direction_protocol <= dirp;
    tick(3);
    reset <= 1'b0;
    tick(3);
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_regs();
    logic [7:0] v;
    @(posedge clk);
    reset <= 1'b1;
    tick(2);
    #1 check("pin_a in reset", 8'h00, {5'h00, pin_a});
    check("oe_a in reset", 8'h00, {7'h00, oe_a});
    @(posedge clk);
    reset <= 1'b0;
    tick(2);
    #1 check("oe_a after reset", 8'h01, {7'h00, oe_a});
    reg_write(2'h3, 8'hFF);
    reg_read(2'h3, v);
    check("unmapped read", 8'h00, v);
    reg_read(2'h2, v);
    check("state run", 8'h20, v & 8'hF0);
    reg_read(2'h1, v);
    check("mask reset", 8'h00, v);
    reg_read(2'h0, v);
    check("status reset", 8'h00, v);
  endtask

  // Both clearable and stuck faults; the mask decides whether the interrupt may show.
  task automatic t_fault(input logic clr, input logic [7:0] mask);
    logic [7:0] v;
    int n;
    do_reset(1'b1, 1'b0);
    reg_write(2'h1, mask);
    diag_clearable <= clr;
    diag_fault <= 1'b1;
    @(posedge clk);
    diag_fault <= 1'b0;
    tick(2);
    #1 check("pin_a fault", {5'h00, `LVL_FAULT_HIGH}, {5'h00, pin_a});
    check("pin_b fault", {5'h00, `LVL_FAULT_HIGH}, {5'h00, pin_b});
    tick(HOLD - 3);
    #1 check("pin_a held", {5'h00, `LVL_FAULT_HIGH}, {5'h00, pin_a});
    n = 0;
    while (ctrl_rst !== 1'b1 && n < 10) begin
      @(posedge clk);
      #1 n++;
    end
    check("ctrl reset seen", {7'h00, clr}, {7'h00, ctrl_rst === 1'b1});
    tick(3);
    #1 check("pin_a after hold", {7'h00, !clr}, {7'h00, pin_a === `LVL_FAULT_HIGH});
    check("controller saw fault", 8'h03, {6'h00, seen_b, seen_a});
    check("irq", {7'h00, mask != 8'h00}, {7'h00, irq});
    reg_read(2'h0, v);
    check("status fault", 8'h03, v & 8'h03);
    reg_write(2'h0, 8'h03);
    reg_read(2'h0, v);
    check("status cleared", 8'h00, v & 8'h03);
    check("irq cleared", 8'h00, {7'h00, irq});
  endtask

  task automatic t_ignore();
    logic [7:0] v;
    do_reset(1'b0, 1'b0);
    diag_fault <= 1'b1;
    @(posedge clk);
    diag_fault <= 1'b0;
    tick(4);
    #1 check("fault refused", 8'h00, {7'h00, pin_a === `LVL_FAULT_HIGH});
    reg_read(2'h0, v);
    check("diag status off", 8'h00, v & 8'h02);
  endtask

  task automatic t_uv();
    do_reset(1'b1, 1'b0);
    uv <= 1'b1;
    tick(3);
    #1 check("pins in uv", 8'h00, {pin_b, pin_a, oe_b, oe_a});
    @(posedge clk);
    uv <= 1'b0;
    tick(3);
    #1 check("oe after uv", 8'h03, {6'h00, oe_b, oe_a});
    check("brief pull-up ignored", 8'h00, {6'h00, seen_b, seen_a});
  endtask

  // Channel A sweeps a large triangle after some jitter; channel B stays flat.
  task automatic t_lockout(input logic dirp, input logic fm);
    int i, p, v, ch_a, ch_b, jit;
    logic [2:0] prev_a, prev_b;
    fixed_mode <= fm;
    do_reset(1'b1, dirp);
    ch_a = 0;
    ch_b = 0;
    jit = 0;
    prev_a = pin_a;
    prev_b = pin_b;
    for (i = 0; i < 1800; i++) begin
      @(posedge clk);
      p = i % 64;
      v = (p < 32) ? -512 + p * 32 : 512 - (p - 32) * 32;
      sample_valid <= 1'b1;
      sample_a <= (i < 200) ? ((i % 2) ? 12'sh020 : -12'sh020) : v[11:0];
      sample_b <= 12'sh000;
      if (pin_a !== prev_a && i < 200) jit++;
      if (pin_a !== prev_a && i > 700) ch_a++;
      if (pin_b !== prev_b && i > 700) ch_b++;
      prev_a = pin_a;
      prev_b = pin_b;
    end
    sample_valid <= 1'b0;
    check("no switching before hysteresis", 8'h00, jit[7:0]);
    check("pin_a switching", {7'h00, !dirp}, {7'h00, ch_a > 0});
    check("pin_b locked", 8'h00, {7'h00, ch_b > 0});
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #(40 * 60000);
    fails++;
    $display("MISMATCH watchdog expected finish seen timeout");
    wrap_up();
  end
  initial begin
    reset = 1'b1;
    uv = 1'b0;
    sample_valid = 1'b0;
    sample_a = 12'sh000;
    sample_b = 12'sh000;
    temp_gain = `GAIN_UNITY;
    fault_detect_en = 1'b1;
    direction_protocol = 1'b0;
    fixed_mode = 1'b0;
    fixed_init_a = 12'sh000;
    fixed_init_b = 12'sh000;
    diag_fault = 1'b0;
    diag_clearable = 1'b0;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    fails = 0;
    comparisons = 0;
    tick(3);
    t_reset_regs();
    t_fault(1'b1, 8'h03);
    t_fault(1'b0, 8'h00);
    t_ignore();
    t_uv();
    t_lockout(1'b0, 1'b0);
    t_lockout(1'b1, 1'b0);
    t_lockout(1'b0, 1'b1);
    wrap_up();
  end
endmodule
